/* hw/pwm_chan_pkg.sv */
//------------------------------------------------------------------------------
// Purpose : Constants shared by the timer channel register file and counter
// Assumes : 32-bit AHB-Lite data, word registers, 16-bit channel counter
// Notes   : Mode codes not listed here behave as the idle (pin) mode, except that leaving one for buffered count raises no flag
//------------------------------------------------------------------------------
package pwm_chan_pkg;

  //----------------------------------------------------------------------------
  // Register byte offsets
  //----------------------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL   = 8'h00; // channel_control_reg
  localparam logic [7:0] OFS_STAT   = 8'h04; // channel_status_reg
  localparam logic [7:0] OFS_CNT    = 8'h08; // Channel count
  localparam logic [7:0] OFS_DATA_A = 8'h0c; // buffer_compare_first
  localparam logic [7:0] OFS_DATA_B = 8'h10; // buffer_compare_second
  localparam logic [7:0] OFS_MASK   = 8'h14; // Interrupt mask

  //----------------------------------------------------------------------------
  // Field layout
  //----------------------------------------------------------------------------
  localparam int CTRL_W    = 11;
  localparam int MODE_LSB  = 0;
  localparam int MODE_MSB  = 6;
  localparam int FEN_BIT   = 7;  // flag_event_enable
  localparam int FRZ_BIT   = 8;  // Freeze
  localparam int PRE_LSB   = 9;  // Prescaler ratio minus one
  localparam int PRE_MSB   = 10;
  localparam int ST_W      = 2;
  localparam int ST_FLAG   = 0;  // Counter event flag
  localparam int ST_WRAP   = 1;  // Counter wrapped past its limit
  localparam int CNT_W     = 16;

  //----------------------------------------------------------------------------
  // Reset values and counter constants
  //----------------------------------------------------------------------------
  localparam logic [CTRL_W-1:0] CTRL_RST = 11'h000;
  localparam logic [ST_W-1:0]   ST_RST   = 2'h0;
  localparam logic [CNT_W-1:0]  CNT_ZERO = 16'h0000;
  localparam logic [CNT_W-1:0]  CNT_ONE  = 16'h0001;
  localparam logic [CNT_W-1:0]  CNT_MAX  = 16'hffff;

  //----------------------------------------------------------------------------
  // Mode codes
  //----------------------------------------------------------------------------
  localparam logic [6:0] MODE_GPIO  = 7'h00;
  localparam logic [6:0] MODE_MC0   = 7'h10; // plain_modulus_count_mode
  localparam logic [6:0] MODE_MC1   = 7'h11;
  localparam logic [6:0] MODE_MCB   = 7'h50; // buffered_modulus_count_mode
  localparam logic [6:0] MODE_FM0   = 7'h58; // freq_width_buffered_pwm_mode
  localparam logic [6:0] MODE_FM1   = 7'h5a;
  localparam logic [6:0] MODE_EDGE  = 7'h60; // edge_buffered_pwm_mode
  localparam logic [6:0] MODE_CTR   = 7'h68; // center_buffered_pwm_mode

endpackage : pwm_chan_pkg

/* hw/chan_if.sv */
//------------------------------------------------------------------------------
// Purpose : Carries settings to the counter engine and its state back
// Assumes : One clock shared by both ends
// Notes   : Event signals are one-cycle pulses
//------------------------------------------------------------------------------
`timescale 1ns/10ps
interface chan_if;
  import pwm_chan_pkg::*;
  logic [6:0]       mode;
  logic [1:0]       pre;
  logic             freeze;
  logic             cnt_wr;
  logic [CNT_W-1:0] cnt_wdata;
  logic [CNT_W-1:0] a2;
  logic [CNT_W-1:0] b2;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] a1;
  logic [CNT_W-1:0] b1;
  logic             match_evt;
  logic             wrap_evt;
  logic             out_lvl;

  modport ctrl (output mode, pre, freeze, cnt_wr, cnt_wdata, a2, b2,
                input  cnt, a1, b1, match_evt, wrap_evt, out_lvl);
  modport engine (input  mode, pre, freeze, cnt_wr, cnt_wdata, a2, b2,
                  output cnt, a1, b1, match_evt, wrap_evt, out_lvl);
endinterface : chan_if

/* hw/pwm_count_engine.sv */
//------------------------------------------------------------------------------
// Purpose : Prescaled channel counter, compare reload and PWM output
// Assumes : Settings arrive from registers on the same clock
// Notes   : Rollover and reload follow the silicon as built
//------------------------------------------------------------------------------
`timescale 1ns/10ps
module pwm_count_engine
  import pwm_chan_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Register side
  chan_if.engine   ch
);

  logic [1:0]       pre_r;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic [CNT_W-1:0] a1_r;
  logic [CNT_W-1:0] b1_r;
  logic             dir_r;
  logic             dir_nxt;
  logic             wrap_r;
  logic             match_r;
  logic             wrapev_r;
  logic             out_r;

  //----------------------------------------------------------------------------
  // Mode decode and counter limit
  //----------------------------------------------------------------------------
  wire              is_mc   = ch.mode == MODE_MC0 || ch.mode == MODE_MC1;
  wire              is_mcb  = ch.mode == MODE_MCB;
  wire              is_fm   = ch.mode == MODE_FM0 || ch.mode == MODE_FM1;
  wire              is_edge = ch.mode == MODE_EDGE;
  wire              is_ctr  = ch.mode == MODE_CTR;
  wire              is_buf  = is_mcb | is_fm | is_edge | is_ctr;
  wire              is_pwm  = is_fm | is_edge | is_ctr;
  wire              tick    = pre_r == ch.pre;
  wire              step    = tick & ~ch.freeze & (is_mc | is_buf);
  wire [CNT_W-1:0]  lim     = is_mc ? ch.a2 : (is_mcb ? a1_r : b1_r);
  wire              at_lim  = cnt_r == lim;
  wire              at_max  = cnt_r == CNT_MAX;
  wire              reload  = step & is_buf & ~wrap_r &
                              (cnt_nxt == CNT_ONE);

  //----------------------------------------------------------------------------
  // Next count
  //----------------------------------------------------------------------------
  always_comb begin
    cnt_nxt = cnt_r + CNT_ONE;
    dir_nxt = dir_r;
    if (is_ctr) begin
      if (dir_r) begin
        if (cnt_r <= CNT_ONE) begin
          dir_nxt = 1'b0;
        end else begin
          cnt_nxt = cnt_r - CNT_ONE;
        end
      end else if (at_lim) begin
        dir_nxt = 1'b1;
        cnt_nxt = cnt_r - CNT_ONE;
      end
    end else if (at_lim || at_max) begin
      cnt_nxt = CNT_ZERO;
    end
  end

  //----------------------------------------------------------------------------
  // Prescaler and counter
  //----------------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pre_r <= 2'h0;
      cnt_r <= CNT_ZERO;
      dir_r <= 1'b0;
    end else begin
      pre_r <= tick ? 2'h0 : pre_r + 2'h1;
      if (ch.cnt_wr && ch.freeze) begin
        cnt_r <= ch.cnt_wdata;
      end else if (step) begin
        cnt_r <= cnt_nxt;
        dir_r <= dir_nxt;
      end
    end
  end

  //----------------------------------------------------------------------------
  // Active compare reload, wrap memory, events and output
  //----------------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      a1_r     <= CNT_ZERO;
      b1_r     <= CNT_ZERO;
      wrap_r   <= 1'b0;
      match_r  <= 1'b0;
      wrapev_r <= 1'b0;
      out_r    <= 1'b0;
    end else begin
      // Outside buffered modes the active pair tracks the buffers, so a
      // buffered mode never starts from an empty limit and stalls at zero
      if (reload || !is_buf) begin
        a1_r <= ch.a2;
        b1_r <= ch.b2;
      end
      if (step && at_max && !at_lim && !is_ctr) begin
        wrap_r <= 1'b1; // Blocks the next reload
      end else if (step && cnt_nxt == CNT_ONE) begin
        wrap_r <= 1'b0;
      end
      match_r  <= step & at_lim;
      wrapev_r <= step & at_max & ~at_lim & ~is_ctr;
      out_r    <= is_pwm & (cnt_r >= a1_r);
    end
  end

  assign ch.cnt       = cnt_r;
  assign ch.a1        = a1_r;
  assign ch.b1        = b1_r;
  assign ch.match_evt = match_r;
  assign ch.wrap_evt  = wrapev_r;
  assign ch.out_lvl   = out_r;

  //----------------------------------------------------------------------------
  // Checks
  //----------------------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  AST_FM_COUNTS_UP: assert property (
    step && is_fm && !at_lim && !at_max && !ch.cnt_wr
    |=> cnt_r == $past(cnt_r) + CNT_ONE)
    else $error("Counter did not step up in frequency PWM mode");

  AST_FREEZE_LOAD: assert property (
    ch.cnt_wr && ch.freeze |=> cnt_r == $past(ch.cnt_wdata))
    else $error("Frozen count write did not load the counter");

  AST_ROLL_TO_ZERO: assert property (
    step && (is_fm || is_mcb) && at_lim && !ch.cnt_wr
    |=> cnt_r == CNT_ZERO ##1 match_r == 1'b0)
    else $error("Buffered rollover did not return to zero");

  AST_NO_RELOAD_AFTER_WRAP: assert property (
    step && is_fm && wrap_r && cnt_r == CNT_ZERO
    |=> a1_r == $past(a1_r) && b1_r == $past(b1_r) && !wrap_r)
    else $error("Compare reloaded after a counter wrap");

  COV_FM_WRAP: cover property (step && is_fm && at_max && !at_lim);
  COV_CTR_TURN: cover property (step && is_ctr && at_lim);

endmodule : pwm_count_engine

/* hw/unified_channel_pwm_counter.sv */
//------------------------------------------------------------------------------
// Purpose : Timer channel with modulus count and buffered PWM modes
// Assumes : AHB-Lite single word transfers, one slave on the bus
// Notes   : Reads take one wait state, writes none, response always OKAY
//------------------------------------------------------------------------------
//------------------------------------------------------------------------------
`timescale 1ns/10ps
module unified_channel_pwm_counter
  import pwm_chan_pkg::*;
(
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output      logic        hreadyout,
  output      logic [31:0] hrdata,
  output      logic        hresp,
  // Interrupt and channel pin
  output      logic        irq,
  output      logic        chan_out
);

  chan_if ch ();

  logic [7:0]        addr_r;
  logic              wr_act_r;
  logic              rd_pend_r;
  logic              hreadyout_r;
  logic [31:0]       hrdata_r;
  logic [CTRL_W-1:0] ctrl_r;
  logic [ST_W-1:0]   stat_r;
  logic [ST_W-1:0]   stat_nxt;
  logic [ST_W-1:0]   mask_r;
  logic [CNT_W-1:0]  a2_r;
  logic [CNT_W-1:0]  b2_r;
  logic              irq_r;
  logic              out_r;

  //----------------------------------------------------------------------------
  // Address phase acceptance and register decode
  //----------------------------------------------------------------------------
  wire        accept   = hsel & hready & htrans[1];
  wire        sel_ctrl = addr_r == OFS_CTRL;
  wire        sel_stat = addr_r == OFS_STAT;
  wire        sel_cnt  = addr_r == OFS_CNT;
  wire        sel_a    = addr_r == OFS_DATA_A;
  wire        sel_b    = addr_r == OFS_DATA_B;
  wire        sel_mask = addr_r == OFS_MASK;
  wire        wr_ctrl  = wr_act_r & sel_ctrl;
  wire        wr_stat  = wr_act_r & sel_stat;
  wire [6:0]  mode_cur = ctrl_r[MODE_MSB:MODE_LSB];
  wire [6:0]  mode_new = hwdata[MODE_MSB:MODE_LSB];
  wire        flag_event_enable      = ctrl_r[FEN_BIT];

  // Mode write leaving the pin mode for buffered count raises the flag
  wire        spur_set = wr_ctrl & (mode_cur == MODE_GPIO) &
                         (mode_new == MODE_MCB);
  wire [ST_W-1:0] clr_vec = wr_stat ? hwdata[ST_W-1:0] : ST_RST;
  wire [ST_W-1:0] set_vec = {ch.wrap_evt, ch.match_evt | spur_set};
  wire [ST_W-1:0] irq_gate = {1'b1, flag_event_enable};

  //----------------------------------------------------------------------------
  // Read data selection
  //----------------------------------------------------------------------------
  wire [31:0] rdata_mux =
    sel_ctrl ? {{(32-CTRL_W){1'b0}}, ctrl_r} :
    sel_stat ? {{(32-ST_W){1'b0}}, stat_r} :
    sel_cnt  ? {{(32-CNT_W){1'b0}}, ch.cnt} :
    sel_a    ? {{(32-CNT_W){1'b0}}, a2_r} :
    sel_b    ? {{(32-CNT_W){1'b0}}, b2_r} :
    sel_mask ? {{(32-ST_W){1'b0}}, mask_r} : 32'h0000_0000;

  // Status: hardware set wins over a write-one clear
  always_comb begin
    stat_nxt = (stat_r & ~clr_vec) | set_vec;
  end

  //----------------------------------------------------------------------------
  // Bus handshake: reads insert one wait state to fetch fresh data
  //----------------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_r      <= 8'h00;
      wr_act_r    <= 1'b0;
      rd_pend_r   <= 1'b0;
      hreadyout_r <= 1'b1;
      hrdata_r    <= 32'h0000_0000;
    end else begin
      wr_act_r    <= accept & hwrite;
      rd_pend_r   <= accept & ~hwrite;
      hreadyout_r <= ~(accept & ~hwrite);
      if (accept) begin
        addr_r <= haddr[7:0];
      end
      if (rd_pend_r) begin
        hrdata_r <= rdata_mux;
      end
    end
  end

  //----------------------------------------------------------------------------
  // Control, buffer and mask registers
  //----------------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r <= CTRL_RST;
      mask_r <= ST_RST;
      a2_r   <= CNT_ZERO;
      b2_r   <= CNT_ZERO;
    end else if (wr_act_r) begin
      if (sel_ctrl) ctrl_r <= hwdata[CTRL_W-1:0];
      if (sel_mask) mask_r <= hwdata[ST_W-1:0];
      if (sel_a)    a2_r   <= hwdata[CNT_W-1:0];
      if (sel_b)    b2_r   <= hwdata[CNT_W-1:0];
    end
  end

  //----------------------------------------------------------------------------
  // Sticky status, interrupt and pin
  //----------------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stat_r <= ST_RST;
      irq_r  <= 1'b0;
      out_r  <= 1'b0;
    end else begin
      stat_r <= stat_nxt;
      irq_r  <= |(stat_r & mask_r & irq_gate);
      out_r  <= ch.out_lvl;
    end
  end

  //----------------------------------------------------------------------------
  // Counter engine hookup
  //----------------------------------------------------------------------------
  assign ch.mode      = mode_cur;
  assign ch.pre       = ctrl_r[PRE_MSB:PRE_LSB];
  assign ch.freeze    = ctrl_r[FRZ_BIT];
  assign ch.cnt_wr    = wr_act_r & sel_cnt;
  assign ch.cnt_wdata = hwdata[CNT_W-1:0];
  assign ch.a2        = a2_r;
  assign ch.b2        = b2_r;

  pwm_count_engine u_engine (
    .hclk    (hclk),
    .hresetn (hresetn),
    .ch      (ch)
  );

  assign hreadyout = hreadyout_r;
  assign hrdata    = hrdata_r;
  assign hresp     = 1'b0;
  assign irq       = irq_r;
  assign chan_out  = out_r;

  //----------------------------------------------------------------------------
  // Checks
  //----------------------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  AST_FLAG_ON_EVENT: assert property (
    ch.match_evt |=> stat_r[ST_FLAG])
    else $error("Counter event did not set the flag");

  AST_FLAG_HOLDS: assert property (
    stat_r[ST_FLAG] && !(wr_stat && hwdata[ST_FLAG])
    |=> stat_r[ST_FLAG])
    else $error("Flag dropped without a clear");

  AST_FLAG_CLEAR: assert property (
    wr_stat && hwdata[ST_FLAG] && !ch.match_evt
    |=> !stat_r[ST_FLAG])
    else $error("Write one did not clear the flag");

  AST_MODE_SWITCH_FLAG: assert property (
    wr_ctrl && mode_cur == MODE_GPIO && mode_new == MODE_MCB
    |=> stat_r[ST_FLAG] && mode_cur == MODE_MCB)
    else $error("Mode switch did not raise the flag");

  AST_IRQ_FOLLOWS: assert property (
    stat_r[ST_FLAG] && mask_r[ST_FLAG] && flag_event_enable |=> irq)
    else $error("Unmasked flag did not raise the interrupt");

  AST_READ_WAIT: assert property (
    accept && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("Read did not take exactly one wait state");

  COV_FLAG_IRQ: cover property (ch.match_evt ##2 irq);
  COV_CLEAR_WRITE: cover property (wr_stat && hwdata[ST_FLAG]);

endmodule : unified_channel_pwm_counter

/* verification/pin_monitor.sv */
//------------------------------------------------------------------------------
// Purpose : Load on the channel pin that counts cycles spent high
// Assumes : Pin sampled on the bus clock, no pull on the line
// Notes   : Bench takes differences of the count over fixed windows
//------------------------------------------------------------------------------
`timescale 1ns/10ps
module pin_monitor (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // Pin and its high-time count
  input  wire logic        chan_out,
  output      logic [15:0] hi_cnt
);
  // Count every cycle the pin is seen high
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hi_cnt <= 16'h0000;
    end else if (chan_out === 1'b1) begin
      hi_cnt <= hi_cnt + 16'h0001;
    end
  end
endmodule : pin_monitor

/* verification/unified_channel_pwm_counter_tb_top.sv */
//------------------------------------------------------------------------------
// Purpose : Self-checking bench for the timer channel over AHB-Lite
// Assumes : One slave, hready fed back from hreadyout
// Notes   : Pin duty measured over windows that span whole periods
//------------------------------------------------------------------------------
`timescale 1ns/10ps
module unified_channel_pwm_counter_tb_top;
  import pwm_chan_pkg::*;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic        hwrite;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  wire  logic        hreadyout;
  wire  logic        hresp;
  wire  logic        irq;
  wire  logic        chan_out;
  wire  logic [31:0] hrdata;
  wire  logic [15:0] hi_cnt;
  int          n_mismatch;
  int          n_compared;

  //----------------------------------------------------------------------------
  // Design and pin load
  //----------------------------------------------------------------------------
  unified_channel_pwm_counter i_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .irq(irq), .chan_out(chan_out));
  pin_monitor i_pin (.hclk(hclk), .hresetn(hresetn), .chan_out(chan_out),
                     .hi_cnt(hi_cnt));

  //----------------------------------------------------------------------------
  // Bus and compare helpers
  //----------------------------------------------------------------------------
  // One single word transfer; waits on hready in both phases
  task automatic xfer(input logic wr, input logic [7:0] ofs,
                      input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {24'h000000, ofs};
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : xfer

  task automatic chk(input string name, input logic [31:0] exp,
                     input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic wr32(input logic [7:0] ofs, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, ofs, d, q);
  endtask : wr32

  task automatic chk_rd(input string name, input logic [7:0] ofs,
                        input logic [31:0] exp);
    logic [31:0] q;
    xfer(1'b0, ofs, 32'h00000000, q);
    chk(name, exp, q);
  endtask : chk_rd

  function automatic logic [31:0] ctl(input logic [6:0] m, input logic flag_event_enable,
                                      input logic frz);
    return {23'h000000, frz, flag_event_enable, m};
  endfunction : ctl

  // High cycles of the pin over a 60-cycle window after settling
  task automatic chk_duty(input string name, input logic [15:0] exp);
    logic [15:0] h0;
    repeat (30) @(posedge hclk);
    h0 = hi_cnt;
    repeat (60) @(posedge hclk);
    chk(name, {16'h0000, exp}, {16'h0000, hi_cnt - h0});
  endtask : chk_duty

  //----------------------------------------------------------------------------
  // Scenarios
  //----------------------------------------------------------------------------
  // Reset values, unmapped offset and quiet outputs
  task automatic t_reset();
    for (int i = 0; i < 7; i++) begin
      chk_rd("reg reset", 8'(i * 4), 32'h00000000);
    end
    chk("irq", 32'h0, {31'h0, irq});
    chk("chan_out", 32'h0, {31'h0, chan_out});
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask : t_reset

  // Count overwrite only while frozen
  task automatic t_freeze();
    wr32(OFS_CTRL, ctl(MODE_GPIO, 1'b0, 1'b1));
    wr32(OFS_CNT, 32'h00001234);
    chk_rd("count frozen", OFS_CNT, 32'h00001234);
    wr32(OFS_CTRL, ctl(MODE_GPIO, 1'b0, 1'b0));
    wr32(OFS_CNT, 32'h00000042);
    chk_rd("count running", OFS_CNT, 32'h00001234);
  endtask : t_freeze

  // Limit events set the flag in both plain codes; one clears it
  task automatic t_flag();
    logic [6:0] codes [2];
    codes = '{MODE_MC0, MODE_MC1};
    wr32(OFS_CTRL, ctl(MODE_GPIO, 1'b0, 1'b1));
    wr32(OFS_CNT, 32'h00000000);
    wr32(OFS_DATA_A, 32'h00000005);
    wr32(OFS_DATA_B, 32'h00000005);
    foreach (codes[i]) begin
      wr32(OFS_STAT, 32'h00000003);
      wr32(OFS_CTRL, ctl(codes[i], 1'b0, 1'b0));
      repeat (20) @(posedge hclk);
      wr32(OFS_CTRL, ctl(codes[i], 1'b0, 1'b1));
      chk_rd("flag set", OFS_STAT, 32'h00000001);
      wr32(OFS_STAT, 32'h00000001);
      chk_rd("flag clear", OFS_STAT, 32'h00000000);
    end
  endtask : t_flag

  // Frequency PWM counts zero to B and rolls to zero: period B+1
  task automatic t_fm();
    wr32(OFS_DATA_A, 32'h00000002);
    wr32(OFS_CTRL, ctl(MODE_FM0, 1'b0, 1'b0));
    chk_duty("duty code 58", 16'd40);
    wr32(OFS_DATA_A, 32'h00000003);
    wr32(OFS_CTRL, ctl(MODE_FM1, 1'b0, 1'b0));
    chk_duty("duty code 5a", 16'd30);
  endtask : t_fm

  // Count above B wraps past the top; reload resumes afterwards
  task automatic t_wrap();
    wr32(OFS_CTRL, ctl(MODE_FM1, 1'b0, 1'b1));
    wr32(OFS_CNT, 32'h0000fff0);
    wr32(OFS_DATA_A, 32'h00000004);
    wr32(OFS_STAT, 32'h00000003);
    wr32(OFS_CTRL, ctl(MODE_FM1, 1'b0, 1'b0));
    repeat (40) @(posedge hclk);
    chk_rd("wrap status", OFS_STAT, 32'h00000003);
    chk_duty("duty after wrap", 16'd20);
  endtask : t_wrap

  // In-range frozen count write, then edge and center PWM from count one
  task automatic t_modes();
    wr32(OFS_CTRL, ctl(MODE_FM1, 1'b0, 1'b1));
    wr32(OFS_CNT, 32'h00000003);
    chk_rd("count in range", OFS_CNT, 32'h00000003);
    wr32(OFS_CTRL, ctl(MODE_GPIO, 1'b0, 1'b1));
    wr32(OFS_DATA_A, 32'h00000001);
    wr32(OFS_CNT, 32'h00000001);
    wr32(OFS_CTRL, ctl(MODE_EDGE, 1'b0, 1'b0));
    chk_duty("duty edge", 16'd50);
    wr32(OFS_CTRL, ctl(MODE_GPIO, 1'b0, 1'b1));
    wr32(OFS_DATA_A, 32'h00000003);
    wr32(OFS_DATA_B, 32'h00000004);
    wr32(OFS_CNT, 32'h00000001);
    wr32(OFS_CTRL, ctl(MODE_CTR, 1'b0, 1'b0));
    chk_duty("duty center", 16'd30);
  endtask : t_modes

  // Pin to buffered count sets flag; mask and enable gate irq
  task automatic t_irq();
    wr32(OFS_CTRL, ctl(MODE_GPIO, 1'b1, 1'b1));
    wr32(OFS_MASK, 32'h00000001);
    wr32(OFS_STAT, 32'h00000003);
    repeat (3) @(posedge hclk);
    chk("irq idle", 32'h0, {31'h0, irq});
    wr32(OFS_CTRL, ctl(MODE_MCB, 1'b1, 1'b1));
    repeat (3) @(posedge hclk);
    chk("irq on switch", 32'h1, {31'h0, irq});
    chk_rd("flag on switch", OFS_STAT, 32'h00000001);
    wr32(OFS_MASK, 32'h00000000);
    repeat (3) @(posedge hclk);
    chk("irq masked", 32'h0, {31'h0, irq});
    wr32(OFS_MASK, 32'h00000001);
    wr32(OFS_STAT, 32'h00000001);
    repeat (3) @(posedge hclk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    // Safe switch: disable, change mode, clear, enable
    wr32(OFS_CTRL, ctl(MODE_GPIO, 1'b0, 1'b1));
    wr32(OFS_CTRL, ctl(MODE_MCB, 1'b0, 1'b1));
    repeat (3) @(posedge hclk);
    chk("irq gated", 32'h0, {31'h0, irq});
    wr32(OFS_STAT, 32'h00000001);
    wr32(OFS_CTRL, ctl(MODE_MCB, 1'b1, 1'b1));
    repeat (3) @(posedge hclk);
    chk("irq safe switch", 32'h0, {31'h0, irq});
    chk_rd("flag safe switch", OFS_STAT, 32'h00000000);
  endtask : t_irq

  //----------------------------------------------------------------------------
  // Verdict, clock, watchdog and main sequence
  //----------------------------------------------------------------------------
  task automatic report_and_stop();
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end

  // Tests need under a thousand cycles; cut a hang well beyond that
  initial begin
    repeat (20000) @(posedge hclk);
    n_mismatch++;
    report_and_stop();
  end

  initial begin
    hresetn = 1'b0;
    hsel    = 1'b0;
    hwrite  = 1'b0;
    haddr   = 32'h00000000;
    hwdata  = 32'h00000000;
    htrans  = 2'h0;
    hsize   = 3'h2;
    n_mismatch = 0;
    n_compared = 0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_freeze();
    t_flag();
    t_fm();
    t_wrap();
    t_modes();
    t_irq();
    report_and_stop();
  end
endmodule : unified_channel_pwm_counter_tb_top
